// ==== rtl/mcrs_core_defines.vh ====
// constants for the core register set: sfr offsets, reset values,
// configuration fields, alu operations and timing
// assumes inclusion by bare name from the rtl files
`ifndef MCRS_CORE_DEFINES_VH
`define MCRS_CORE_DEFINES_VH

// sfr offsets
`define MCRS_ADDR_STACK_TOP     8'h81
`define MCRS_ADDR_PTR_LOW       8'h82
`define MCRS_ADDR_PTR_HIGH      8'h83
`define MCRS_ADDR_CONFIG        8'haf
`define MCRS_ADDR_STATUS        8'hd0
`define MCRS_ADDR_ACC           8'he0
`define MCRS_ADDR_BREG          8'hf0

// reset values
`define MCRS_RST_STACK_TOP      8'h07
`define MCRS_RST_PTR_LOW        8'h00
`define MCRS_RST_PTR_HIGH       8'h00
`define MCRS_RST_CONFIG         8'h81
`define MCRS_RST_PC             16'h0000
`define MCRS_RST_BYTE           8'h00

// configuration fields
`define MCRS_CFG_KEEP_BIT       7
`define MCRS_CFG_UART_BIT       6
`define MCRS_CFG_OWNER_BIT      5
`define MCRS_CFG_MOD_BIT        4
`define MCRS_CFG_XRAM_HI_BIT    1
`define MCRS_CFG_XRAM_LO_BIT    0

// status word fields
`define MCRS_PSW_CY             7
`define MCRS_PSW_AC             6
`define MCRS_PSW_BANK_HI        4
`define MCRS_PSW_BANK_LO        3
`define MCRS_PSW_OV             2
`define MCRS_PSW_PAR            0

// alu operations
`define MCRS_OP_ADD             3'h0
`define MCRS_OP_ADDC            3'h1
`define MCRS_OP_SUBB            3'h2
`define MCRS_OP_AND             3'h3
`define MCRS_OP_OR              3'h4
`define MCRS_OP_XOR             3'h5
`define MCRS_OP_MUL             3'h6
`define MCRS_OP_DIV             3'h7

// operand sources
`define MCRS_SRC_BANK           2'h0
`define MCRS_SRC_LITERAL        2'h1
`define MCRS_SRC_RAM            2'h2

// timing
`define MCRS_CLK_HZ             25000000
`define MCRS_CARRIER_HZ         38000
`define MCRS_CARRIER_HALF       (`MCRS_CLK_HZ / (2 * `MCRS_CARRIER_HZ))

`endif

// ==== rtl/mcrs_alu.v ====
// arithmetic and logic unit with carry, auxiliary carry and overflow
// assumes purely combinational use by the register set top
`timescale 1ns/1ns
`include "mcrs_core_defines.vh"

module mcrs_alu (
    // operation
    input  wire [2:0] aluOp,
    input  wire [7:0] accIn,
    input  wire [7:0] operandIn,
    input  wire [7:0] bRegIn,
    input  wire       carryIn,
    // results
    output reg  [7:0] accOut,
    output reg  [7:0] bRegOut,
    output reg        bRegWrite,
    output reg        carryOut,
    output reg        auxCarryOut,
    output reg        auxCarryWrite,
    output reg        overflowOut,
    output reg        flagWrite
);
    reg  [8:0]  sum;
    reg  [4:0]  nib;
    reg  [15:0] prod;
    reg         cin;

    always @*
    begin
        sum           = 9'h000;
        nib           = 5'h00;
        prod          = 16'h0000;
        cin           = 1'b0;
        accOut        = accIn;
        bRegOut       = bRegIn;
        bRegWrite     = 1'b0;
        carryOut      = carryIn;
        auxCarryOut   = 1'b0;
        auxCarryWrite = 1'b0;
        overflowOut   = 1'b0;
        flagWrite     = 1'b0;
        case (aluOp)
            `MCRS_OP_ADD, `MCRS_OP_ADDC:
            begin
                cin           = (aluOp == `MCRS_OP_ADDC) ? carryIn : 1'b0;
                sum           = {1'b0, accIn} + {1'b0, operandIn} + {8'h00, cin};
                nib           = {1'b0, accIn[3:0]} + {1'b0, operandIn[3:0]} + {4'h0, cin};
                accOut        = sum[7:0];
                carryOut      = sum[8];
                auxCarryOut   = nib[4];
                auxCarryWrite = 1'b1;
                overflowOut   = (accIn[7] == operandIn[7]) && (sum[7] != accIn[7]);
                flagWrite     = 1'b1; // RL19
            end
            `MCRS_OP_SUBB:
            begin
                sum           = {1'b0, accIn} - {1'b0, operandIn} - {8'h00, carryIn};
                nib           = {1'b0, accIn[3:0]} - {1'b0, operandIn[3:0]} - {4'h0, carryIn};
                accOut        = sum[7:0];
                carryOut      = sum[8];
                auxCarryOut   = nib[4];
                auxCarryWrite = 1'b1;
                overflowOut   = (accIn[7] != operandIn[7]) && (sum[7] != accIn[7]);
                flagWrite     = 1'b1; // RL19
            end
            `MCRS_OP_AND: accOut = accIn & operandIn;
            `MCRS_OP_OR:  accOut = accIn | operandIn;
            `MCRS_OP_XOR: accOut = accIn ^ operandIn;
            `MCRS_OP_MUL:
            begin
                prod        = {8'h00, accIn} * {8'h00, bRegIn}; // RL18
                accOut      = prod[7:0];
                bRegOut     = prod[15:8];
                bRegWrite   = 1'b1;
                carryOut    = 1'b0;
                overflowOut = (prod[15:8] != 8'h00);
                flagWrite   = 1'b1;
            end
            default:
            begin
                // divide by zero leaves both operands and flags overflow
                if (bRegIn != 8'h00)
                begin
                    accOut  = accIn / bRegIn; // RL18
                    bRegOut = accIn % bRegIn;
                end
                bRegWrite   = 1'b1;
                carryOut    = 1'b0;
                overflowOut = (bRegIn == 8'h00);
                flagWrite   = 1'b1;
            end
        endcase
    end
endmodule // mcrs_alu

// ==== rtl/mcrs_register_set.v ====
// architectural register set of the 8-bit core: pointers, configuration,
// fetch counter, opcode holder, register banks, accumulator, b and status
// assumes a core sequencer driving the sfr, bit, bank and alu strobes
`timescale 1ns/1ns
`include "mcrs_core_defines.vh"

// Notes on behaviour
// RL1: low pointer byte register, resets zero
// RL2: high pointer byte register, resets zero
// RL3: sixteen-bit pointer is high and low bytes
// RL4: stack pointer byte, resets to seven
// RL5: software keeps configuration bit seven set
// RL6: bit six selects enhanced uart
// RL7: bit five hands shared pins to spi
// RL8: bit four enables carrier on masked pins
// RL9: software keeps configuration bits three, two zero
// RL10: either xram bit enables external moves
// RL11: fetch counter resets zero, adds length
// RL12: fetch counter only by fetch, call, jump
// RL13: opcode holder hidden from software
// RL14: four banks of eight bytes, 32 total
// RL15: bank operand one cycle, others two
// RL16: status bank bits choose active bank
// RL17: parity flag always tracks accumulator
// RL18: b feeds multiply, divide, else scratch
// RL19: status word flags carry, aux, overflow; bit writes
// RL20: bank n maps to bytes 8n..8n+7
module mcrs_register_set (
    // clock and reset
    input  wire        clk,
    input  wire        resetn,
    // special register port
    input  wire [7:0]  sfrAddr,
    input  wire        sfrWrEn,
    input  wire [7:0]  sfrWrData,
    input  wire        sfrRdEn,
    output reg  [7:0]  sfrRdData,
    // status word bit port
    input  wire        statusBitWrEn,
    input  wire [2:0]  statusBitSel,
    input  wire        statusBitVal,
    // pointer word port
    input  wire        pointerWordWrEn,
    input  wire [15:0] pointerWordIn,
    output reg  [15:0] pointerValue,
    // fetch and opcode
    input  wire        fetchAdvance,
    input  wire [1:0]  instrLength,
    input  wire        fetchLoad,
    input  wire [15:0] fetchLoadAddr,
    input  wire        opcodeLoad,
    input  wire [7:0]  opcodeIn,
    output reg  [15:0] fetchAddressCounter,
    output reg  [7:0]  opcodeHolder,
    // register bank port
    input  wire [2:0]  bankRegSel,
    input  wire        bankWrEn,
    input  wire [7:0]  bankWrData,
    input  wire        bankRdEn,
    output reg  [7:0]  bankRdData,
    // alu request
    input  wire        aluStart,
    input  wire [2:0]  aluOp,
    input  wire [1:0]  aluSrc,
    input  wire [7:0]  aluOperand,
    output reg         aluBusy,
    output reg         aluDone,
    // core state
    output reg  [7:0]  accumulatorReg,
    output reg  [7:0]  statusWord,
    output reg  [7:0]  stackTopPointer,
    // configuration outputs
    output reg         uartEnhancedSelect,
    output reg         sharedSerialOwnerSelect,
    output reg         xramAccessEnable,
    // carrier modulation
    input  wire [7:0]  carrierPinMask,
    input  wire [7:0]  portPinData,
    output reg  [7:0]  portPinOut
);
    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;
    localparam integer CARRIER_HALF = `MCRS_CARRIER_HALF;

    reg  [7:0]  ptrLow_r;
    reg  [7:0]  ptrHigh_r;
    reg  [7:0]  config_r;
    reg  [7:0]  bReg_r;
    reg  [7:0]  acc_nxt;
    reg  [7:0]  bReg_nxt;
    reg  [7:0]  psw_nxt;
    reg  [7:0]  bankRam [0:31];
    reg         state_r;
    reg  [2:0]  heldOp_r;
    reg  [7:0]  heldOperand_r;
    reg  [8:0]  carrierCnt_r;
    reg         carrierPhase_r;
    reg  [7:0]  aluOperandSel;
    reg  [2:0]  aluOpSel;
    reg         aluCommit;
    reg  [7:0]  rdMux;
    wire [7:0]  aluAcc;
    wire [7:0]  aluB;
    wire        aluBWr;
    wire        aluCy;
    wire        aluAc;
    wire        aluAcWr;
    wire        aluOv;
    wire        aluFlagWr;
    integer     i;

    // bank register location from bank bits and register number
    function [4:0] bankIndex;
        input [7:0] status_word;
        input [2:0] reg_sel;
        begin
            bankIndex = {status_word[`MCRS_PSW_BANK_HI:`MCRS_PSW_BANK_LO], reg_sel}; // RL16 RL20
        end
    endfunction

    // operand selection and completion timing
    always @*
    begin
        aluCommit     = 1'b0;
        aluOpSel      = heldOp_r;
        aluOperandSel = heldOperand_r;
        if (state_r == ST_WAIT)
        begin
            aluCommit = 1'b1; // RL15
        end
        else if (aluStart && aluSrc == `MCRS_SRC_BANK)
        begin
            aluCommit     = 1'b1; // RL15
            aluOpSel      = aluOp;
            aluOperandSel = bankRam[bankIndex(statusWord, bankRegSel)];
        end
    end

    mcrs_alu u_alu (
        .aluOp         (aluOpSel),
        .accIn         (accumulatorReg),
        .operandIn     (aluOperandSel),
        .bRegIn        (bReg_r),
        .carryIn       (statusWord[`MCRS_PSW_CY]),
        .accOut        (aluAcc),
        .bRegOut       (aluB),
        .bRegWrite     (aluBWr),
        .carryOut      (aluCy),
        .auxCarryOut   (aluAc),
        .auxCarryWrite (aluAcWr),
        .overflowOut   (aluOv),
        .flagWrite     (aluFlagWr)
    );

    // next accumulator, b and status; alu results win over sfr writes
    always @*
    begin
        acc_nxt  = accumulatorReg;
        bReg_nxt = bReg_r;
        psw_nxt  = statusWord;
        if (sfrWrEn && sfrAddr == `MCRS_ADDR_ACC)
            acc_nxt = sfrWrData;
        if (sfrWrEn && sfrAddr == `MCRS_ADDR_BREG)
            bReg_nxt = sfrWrData; // RL18
        if (sfrWrEn && sfrAddr == `MCRS_ADDR_STATUS)
            psw_nxt = sfrWrData;
        if (statusBitWrEn)
            psw_nxt[statusBitSel] = statusBitVal; // RL19
        if (aluCommit)
        begin
            acc_nxt = aluAcc;
            if (aluBWr)
                bReg_nxt = aluB;
            if (aluFlagWr)
            begin
                psw_nxt[`MCRS_PSW_CY] = aluCy; // RL19
                psw_nxt[`MCRS_PSW_OV] = aluOv;
            end
            if (aluAcWr)
                psw_nxt[`MCRS_PSW_AC] = aluAc;
        end
        // parity is never stored from software, only from the accumulator
        psw_nxt[`MCRS_PSW_PAR] = ^acc_nxt; // RL17
    end

    // register read mux; fetch counter and opcode holder are not mapped
    always @*
    begin
        case (sfrAddr)
            `MCRS_ADDR_STACK_TOP: rdMux = stackTopPointer;
            `MCRS_ADDR_PTR_LOW:   rdMux = ptrLow_r;
            `MCRS_ADDR_PTR_HIGH:  rdMux = ptrHigh_r;
            `MCRS_ADDR_CONFIG:    rdMux = config_r;
            `MCRS_ADDR_STATUS:    rdMux = statusWord;
            `MCRS_ADDR_ACC:       rdMux = accumulatorReg;
            `MCRS_ADDR_BREG:      rdMux = bReg_r;
            default:              rdMux = 8'h00; // RL12 RL13
        endcase
    end

    // special registers
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ptrLow_r        <= `MCRS_RST_PTR_LOW; // RL1
            ptrHigh_r       <= `MCRS_RST_PTR_HIGH; // RL2
            stackTopPointer <= `MCRS_RST_STACK_TOP; // RL4
            config_r        <= `MCRS_RST_CONFIG; // RL10
            accumulatorReg  <= `MCRS_RST_BYTE;
            bReg_r          <= `MCRS_RST_BYTE;
            statusWord      <= `MCRS_RST_BYTE;
            sfrRdData       <= `MCRS_RST_BYTE;
        end
        else
        begin
            accumulatorReg <= acc_nxt;
            bReg_r         <= bReg_nxt;
            statusWord     <= psw_nxt;
            if (sfrRdEn)
                sfrRdData <= rdMux;
            if (sfrWrEn && sfrAddr == `MCRS_ADDR_STACK_TOP)
                stackTopPointer <= sfrWrData; // RL4
            if (sfrWrEn && sfrAddr == `MCRS_ADDR_CONFIG)
                config_r <= sfrWrData;
            // a word write replaces both bytes; byte writes are independent
            if (pointerWordWrEn)
            begin
                ptrHigh_r <= pointerWordIn[15:8]; // RL3
                ptrLow_r  <= pointerWordIn[7:0];
            end
            else
            begin
                if (sfrWrEn && sfrAddr == `MCRS_ADDR_PTR_LOW)
                    ptrLow_r <= sfrWrData; // RL1 RL3
                if (sfrWrEn && sfrAddr == `MCRS_ADDR_PTR_HIGH)
                    ptrHigh_r <= sfrWrData; // RL2 RL3
            end
        end
    end

    // pointer value output follows the byte registers one cycle later
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pointerValue <= {`MCRS_RST_PTR_HIGH, `MCRS_RST_PTR_LOW};
        else
            pointerValue <= {ptrHigh_r, ptrLow_r}; // RL3
    end

    // configuration decode into flopped controls
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            uartEnhancedSelect      <= 1'b0;
            sharedSerialOwnerSelect <= 1'b0;
            xramAccessEnable        <= 1'b1;
        end
        else
        begin
            uartEnhancedSelect      <= config_r[`MCRS_CFG_UART_BIT]; // RL6
            sharedSerialOwnerSelect <= config_r[`MCRS_CFG_OWNER_BIT]; // RL7
            xramAccessEnable        <= config_r[`MCRS_CFG_XRAM_HI_BIT] |
                                       config_r[`MCRS_CFG_XRAM_LO_BIT]; // RL10
        end
    end

    // fetch counter and opcode holder, reachable only from the sequencer
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fetchAddressCounter <= `MCRS_RST_PC; // RL11
            opcodeHolder        <= `MCRS_RST_BYTE;
        end
        else
        begin
            // a call or jump target overrides sequential advance
            if (fetchLoad)
                fetchAddressCounter <= fetchLoadAddr; // RL12
            else if (fetchAdvance)
                fetchAddressCounter <= fetchAddressCounter + {14'h0000, instrLength}; // RL11
            if (opcodeLoad)
                opcodeHolder <= opcodeIn; // RL13
        end
    end

    // bank storage: low 32 bytes of internal ram
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (i = 0; i < 32; i = i + 1)
                bankRam[i] <= `MCRS_RST_BYTE; // RL14
            bankRdData <= `MCRS_RST_BYTE;
        end
        else
        begin
            if (bankWrEn)
                bankRam[bankIndex(statusWord, bankRegSel)] <= bankWrData; // RL14 RL16
            if (bankRdEn)
                bankRdData <= bankRam[bankIndex(statusWord, bankRegSel)];
        end
    end

    // alu sequencing: literal and ram operands take a second cycle
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r       <= ST_IDLE;
            heldOp_r      <= `MCRS_OP_ADD;
            heldOperand_r <= `MCRS_RST_BYTE;
            aluBusy       <= 1'b0;
            aluDone       <= 1'b0;
        end
        else
        begin
            aluDone <= aluCommit;
            case (state_r)
                ST_IDLE:
                begin
                    if (aluStart && aluSrc != `MCRS_SRC_BANK)
                    begin
                        state_r       <= ST_WAIT; // RL15
                        heldOp_r      <= aluOp;
                        heldOperand_r <= aluOperand;
                        aluBusy       <= 1'b1;
                    end
                end
                ST_WAIT:
                begin
                    state_r <= ST_IDLE;
                    aluBusy <= 1'b0;
                end
                default:
                begin
                    state_r <= ST_IDLE;
                    aluBusy <= 1'b0;
                end
            endcase
        end
    end

    // carrier generator; half period rounds down, so slightly above nominal
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            carrierCnt_r   <= 9'h000;
            carrierPhase_r <= 1'b0;
            portPinOut     <= 8'h00;
        end
        else
        begin
            if (carrierCnt_r == CARRIER_HALF[8:0] - 9'h001)
            begin
                carrierCnt_r   <= 9'h000;
                carrierPhase_r <= ~carrierPhase_r;
            end
            else
                carrierCnt_r <= carrierCnt_r + 9'h001;
            if (config_r[`MCRS_CFG_MOD_BIT])
                portPinOut <= portPinData & ~(carrierPinMask & {8{~carrierPhase_r}}); // RL8
            else
                portPinOut <= portPinData; // RL8
        end
    end
endmodule // mcrs_register_set

// ==== sim/mcrs_register_set_monitor.sv ====
// concurrent checks on the core register set ports
// assumes a bind onto mcrs_register_set, one clock domain
`timescale 1ns/1ns
`include "mcrs_core_defines.vh"
module mcrs_register_set_monitor (
    // clock and reset
    input logic        clk,
    input logic        resetn,
    // sfr and pointer
    input logic [7:0]  sfrAddr,
    input logic        sfrWrEn,
    input logic [7:0]  sfrWrData,
    input logic        pointerWordWrEn,
    input logic [15:0] pointerWordIn,
    input logic [15:0] pointerValue,
    input logic [7:0]  stackTopPointer,
    // fetch and opcode
    input logic        fetchAdvance,
    input logic [1:0]  instrLength,
    input logic        fetchLoad,
    input logic [15:0] fetchLoadAddr,
    input logic [15:0] fetchAddressCounter,
    input logic        opcodeLoad,
    input logic [7:0]  opcodeIn,
    input logic [7:0]  opcodeHolder,
    // alu and state
    input logic        aluStart,
    input logic [1:0]  aluSrc,
    input logic        aluBusy,
    input logic        aluDone,
    input logic [7:0]  accumulatorReg,
    input logic [7:0]  statusWord,
    // configuration
    input logic        uartEnhancedSelect,
    input logic        sharedSerialOwnerSelect,
    input logic        xramAccessEnable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    wire cfgWr = sfrWrEn && sfrAddr == `MCRS_ADDR_CONFIG;

    ptr_word_a:
        assert property (pointerWordWrEn |-> ##2 pointerValue == $past(pointerWordIn, 2))
        else $error("pointer word not seen");
    stack_write_a:
        assert property (sfrWrEn && sfrAddr == `MCRS_ADDR_STACK_TOP
            |=> stackTopPointer == $past(sfrWrData)) else $error("stack write lost");
    uart_select_a:
        assert property (cfgWr |-> ##2 uartEnhancedSelect == $past(sfrWrData[6], 2))
        else $error("uart select wrong");
    owner_select_a:
        assert property (cfgWr |-> ##2 sharedSerialOwnerSelect == $past(sfrWrData[5], 2))
        else $error("serial owner wrong");
    xram_enable_a:
        assert property (cfgWr |-> ##2 xramAccessEnable == |$past(sfrWrData[1:0], 2))
        else $error("xram enable wrong");
    parity_track_a:
        assert property (statusWord[0] == ^accumulatorReg) else $error("parity stale");
    fetch_advance_a:
        assert property (fetchAdvance && !fetchLoad |=> fetchAddressCounter
            == $past(fetchAddressCounter) + $past(instrLength)) else $error("bad advance");
    fetch_load_a:
        assert property (fetchLoad |=> fetchAddressCounter == $past(fetchLoadAddr))
        else $error("fetch load lost");
    opcode_load_a:
        assert property (opcodeLoad |=> opcodeHolder == $past(opcodeIn))
        else $error("opcode not held");
    alu_bank_a:
        assert property (aluStart && !aluBusy && aluSrc == `MCRS_SRC_BANK
            |=> aluDone && !aluBusy) else $error("bank op not single cycle");
    alu_two_a:
        assert property (aluStart && !aluBusy && aluSrc != `MCRS_SRC_BANK
            |=> aluBusy && !aluDone ##1 aluDone && !aluBusy) else $error("two cycle op wrong");

    cover property (aluStart && aluSrc == `MCRS_SRC_BANK);
    cover property (aluBusy ##1 aluDone);
    cover property (fetchLoad && fetchAdvance);
endmodule // mcrs_register_set_monitor

// ==== sim/test_mcrs_register_set.sv ====
// self-checking bench for the core register set
// assumes rtl and monitor compiled first; inputs move 1 ns after clk rise
`timescale 1ns/1ns
`include "mcrs_core_defines.vh"
module test_mcrs_register_set;
    logic        clk, resetn, sfrWrEn, sfrRdEn, statusBitWrEn, statusBitVal;
    logic        pointerWordWrEn, fetchAdvance, fetchLoad, opcodeLoad, bankWrEn;
    logic        bankRdEn, aluStart, aluBusy, aluDone, uartEnhancedSelect;
    logic        sharedSerialOwnerSelect, xramAccessEnable;
    logic [7:0]  sfrAddr, sfrWrData, sfrRdData, bankWrData, bankRdData, aluOperand;
    logic [7:0]  opcodeIn, opcodeHolder, accumulatorReg, statusWord, stackTopPointer;
    logic [7:0]  carrierPinMask, portPinData, portPinOut;
    logic [15:0] pointerWordIn, pointerValue, fetchLoadAddr, fetchAddressCounter;
    logic [2:0]  statusBitSel, bankRegSel, aluOp;
    logic [1:0]  instrLength, aluSrc;
    logic [7:0]  cfgTab [5] = '{8'hc1, 8'ha0, 8'h82, 8'h83, 8'h80};
    int          num_errors, checked, lowCnt, i;
    wire [2:0]   cfgOut = {uartEnhancedSelect, sharedSerialOwnerSelect, xramAccessEnable};

    mcrs_register_set uut (.clk, .resetn, .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdEn,
        .sfrRdData, .statusBitWrEn, .statusBitSel, .statusBitVal, .pointerWordWrEn,
        .pointerWordIn, .pointerValue, .fetchAdvance, .instrLength, .fetchLoad,
        .fetchLoadAddr, .opcodeLoad, .opcodeIn, .fetchAddressCounter, .opcodeHolder,
        .bankRegSel, .bankWrEn, .bankWrData, .bankRdEn, .bankRdData, .aluStart, .aluOp,
        .aluSrc, .aluOperand, .aluBusy, .aluDone, .accumulatorReg, .statusWord,
        .stackTopPointer, .uartEnhancedSelect, .sharedSerialOwnerSelect,
        .xramAccessEnable, .carrierPinMask, .portPinData, .portPinOut);

    initial
    begin
        clk = 0;
        forever #20 clk = ~clk;
    end

    task tick;
        @(posedge clk);
        #1;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfrAddr = a;
        sfrWrData = d;
        sfrWrEn = 1;
        tick;
        sfrWrEn = 0;
        tick;
    endtask
    task sfr_rd(input logic [7:0] a, input logic [7:0] exp);
        sfrAddr = a;
        sfrRdEn = 1;
        tick;
        sfrRdEn = 0;
        chk(sfrRdData, exp);
        tick;
    endtask
    task set_bank(input logic [1:0] n);
        statusBitWrEn = 1;
        statusBitSel = 3'h4;
        statusBitVal = n[1];
        tick;
        statusBitSel = 3'h3;
        statusBitVal = n[0];
        tick;
        statusBitWrEn = 0;
        tick;
    endtask
    task bank_op(input logic wr, input logic [2:0] r, input logic [7:0] d);
        bankRegSel = r;
        bankWrData = d;
        bankWrEn = wr;
        bankRdEn = !wr;
        tick;
        {bankWrEn, bankRdEn} = 2'h0;
        if (!wr)
            chk(bankRdData, d);
        tick;
    endtask
    task alu(input logic [2:0] op, input logic [1:0] src, input logic [7:0] v,
             input logic [7:0] accExp, input logic [7:0] pswExp);
        aluOp = op;
        aluSrc = src;
        aluOperand = v;
        aluStart = 1;
        tick;
        aluStart = 0;
        if (src != `MCRS_SRC_BANK)
        begin
            chk(aluBusy, 1'b1);
            tick;
        end
        chk(aluDone, 1'b1);
        chk(accumulatorReg, accExp);
        chk(statusWord, pswExp);
        tick;
    endtask
    task stop_test;
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        {sfrWrEn, sfrRdEn, statusBitWrEn, statusBitVal, pointerWordWrEn} = '0;
        {fetchAdvance, fetchLoad, opcodeLoad, bankWrEn, bankRdEn, aluStart} = '0;
        {sfrAddr, sfrWrData, bankWrData, aluOperand, opcodeIn, carrierPinMask} = '0;
        {portPinData, pointerWordIn, fetchLoadAddr, statusBitSel, bankRegSel} = '0;
        {aluOp, instrLength, aluSrc} = '0;
        resetn = 0;
        repeat (4) @(posedge clk);
        #1;
        resetn = 1;
        chk(stackTopPointer, 8'h07);
        chk(pointerValue, 16'h0000);
        chk(fetchAddressCounter, 16'h0000);
        chk(cfgOut, 3'h1);
        sfr_rd(8'h82, 8'h00);
        sfr_rd(8'h83, 8'h00);
        sfr_rd(8'haf, 8'h81);
        $display("test reset done");

        sfr_wr(8'h82, 8'ha5);
        sfr_wr(8'h83, 8'h3c);
        chk(pointerValue, 16'h3ca5);
        pointerWordIn = 16'h1234;
        pointerWordWrEn = 1;
        tick;
        pointerWordWrEn = 0;
        sfr_rd(8'h82, 8'h34);
        sfr_rd(8'h83, 8'h12);
        sfr_wr(8'h82, 8'hff);
        chk(pointerValue, 16'h12ff);
        sfr_wr(8'h81, 8'h40);
        sfr_wr(8'h84, 8'h5a);
        sfr_rd(8'h81, 8'h40);
        sfr_rd(8'h84, 8'h00);
        $display("test pointers done");

        for (i = 0; i < 5; i++)
        begin
            sfr_wr(8'haf, cfgTab[i]);
            chk(cfgOut, {cfgTab[i][6:5], |cfgTab[i][1:0]});
        end
        // a full period is half low on masked pins
        portPinData = 8'hff;
        carrierPinMask = 8'h0f;
        sfr_wr(8'haf, 8'h91);
        lowCnt = 0;
        repeat (656)
        begin
            tick;
            lowCnt += (portPinOut[3:0] == 4'h0);
            chk(portPinOut[7:4], 4'hf);
        end
        chk(lowCnt[15:0], 16'h0148);
        sfr_wr(8'haf, 8'h81);
        portPinData = 8'h5a;
        repeat (3) tick;
        chk(portPinOut, 8'h5a);
        $display("test configuration done");

        for (i = 1; i < 4; i++)
        begin
            fetchAdvance = 1;
            instrLength = i[1:0];
            tick;
        end
        fetchAdvance = 0;
        chk(fetchAddressCounter, 16'h0006);
        {fetchLoad, fetchAdvance} = 2'h3;
        fetchLoadAddr = 16'h1234;
        opcodeIn = 8'h74;
        opcodeLoad = 1;
        tick;
        {fetchLoad, fetchAdvance, opcodeLoad} = 3'h0;
        tick;
        chk(fetchAddressCounter, 16'h1234);
        chk(opcodeHolder, 8'h74);
        $display("test fetch done");

        for (i = 0; i < 8; i++)
        begin
            set_bank(i[1:0]);
            bank_op(i < 4, 3'h7, 8'h10 + i[7:0] % 8'h4);
        end
        set_bank(2'h1);
        bank_op(1'b1, 3'h2, 8'h11);
        sfr_wr(8'he0, 8'h01);
        alu(3'h0, 2'h0, 8'h00, 8'h12, 8'h08);
        alu(3'h5, 2'h2, 8'h01, 8'h13, 8'h09);
        alu(3'h0, 2'h1, 8'hf0, 8'h03, 8'h88);
        alu(3'h1, 2'h1, 8'h0c, 8'h10, 8'h49);
        alu(3'h2, 2'h1, 8'h11, 8'hff, 8'hc8);
        alu(3'h3, 2'h1, 8'h0f, 8'h0f, 8'hc8);
        alu(3'h4, 2'h1, 8'h30, 8'h3f, 8'hc8);
        sfr_wr(8'hf0, 8'h05);
        alu(3'h6, 2'h1, 8'h00, 8'h3b, 8'h4d);
        sfr_rd(8'hf0, 8'h01);
        sfr_wr(8'hf0, 8'h04);
        alu(3'h7, 2'h1, 8'h00, 8'h0e, 8'h49);
        sfr_rd(8'hf0, 8'h03);
        $display("test banks and alu done");
        stop_test;
    end
endmodule // test_mcrs_register_set

bind mcrs_register_set mcrs_register_set_monitor u_mon (.clk, .resetn, .sfrAddr, .sfrWrEn,
    .sfrWrData, .pointerWordWrEn, .pointerWordIn, .pointerValue, .stackTopPointer,
    .fetchAdvance, .instrLength, .fetchLoad, .fetchLoadAddr, .fetchAddressCounter,
    .opcodeLoad, .opcodeIn, .opcodeHolder, .aluStart, .aluSrc, .aluBusy, .aluDone,
    .accumulatorReg, .statusWord, .uartEnhancedSelect, .sharedSerialOwnerSelect,
    .xramAccessEnable);
